// ---- rtl/sar_adc_pkg.sv ----
`default_nettype none
package sar_adc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map.
  localparam logic [7:0] DATA_OFS    = 8'hd0;
  localparam logic [7:0] CTRL_OFS    = 8'hd1;
  localparam logic [7:0] STATUS_OFS  = 8'hd2;
  localparam logic [7:0] MASK_OFS    = 8'hd3;

  // Control register fields.
  localparam int         CTRL_IE_BIT    = 7;
  localparam int         CTRL_EOC_BIT   = 6;
  localparam int         CTRL_START_BIT = 5;
  localparam int         CTRL_PWR_BIT   = 4;
  localparam logic [7:0] CTRL_RESET     = 8'h40;

  // Event status and mask fields.
  localparam int         EV_DONE_BIT  = 0;
  localparam int         EV_ABORT_BIT = 1;
  localparam int         EV_NUM       = 2;
  localparam logic [1:0] MASK_RESET   = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: the reference conversion time at the reference oscillator.
  localparam int OSC_REF_KHZ  = 8000;
  localparam int CONV_TIME_NS = 70000;
  localparam int TICK_DIV     = 12;
  localparam int RES_BITS     = 8;
  localparam int BIT_TICKS    = 5;
  localparam int CONV_TICKS   =
    CONV_TIME_NS * (OSC_REF_KHZ / 1000) / 1000 / TICK_DIV;
  localparam int SAMPLE_TICKS = CONV_TICKS - RES_BITS * BIT_TICKS;
  localparam int CONV_CYCLES  = CONV_TICKS * TICK_DIV;

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_SAMPLE = 2'b01,
    PH_BITS   = 2'b10
  } phase_e;

  typedef struct packed {
    logic [7:0]  rdata;
    logic        irq;
    logic        busy;
    logic        done_irq_enable;
    logic        eoc;
    logic        converter_power_select;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [7:0]  result;
    logic [7:0]  trial;
    logic [2:0]  bit_idx;
    logic [5:0]  tick_cnt;
    phase_e      phase;
  } adc_state_s;

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } div_state_s;

  typedef struct packed {
    logic meta;
    logic sync;
  } sync_state_s;

endpackage
`default_nettype wire

// ---- rtl/level_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module level_sync (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic level_in,
  output logic      level_out
);

  sar_adc_pkg::sync_state_s st_q;
  sar_adc_pkg::sync_state_s st_d;

  // The first stage feeds only the second stage.
  always_comb
  begin
    st_d.meta = level_in;
    st_d.sync = st_q.meta;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.sync;

endmodule // level_sync
`default_nettype wire

// ---- rtl/conv_tick_divider.sv ----
`timescale 1ns/10ps
`default_nettype none
module conv_tick_divider (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic restart_in,
  input  wire logic run_in,
  output logic      tick_out
);

  localparam logic [3:0] DIV_LAST = 4'(sar_adc_pkg::TICK_DIV - 1);

  sar_adc_pkg::div_state_s st_q;
  sar_adc_pkg::div_state_s st_d;

  // Restart realigns the divider so every conversion has the same length.
  always_comb
  begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (restart_in || !run_in)
    begin
      st_d.cnt = 4'h0;
    end
    else if (st_q.cnt == DIV_LAST)
    begin
      st_d.cnt = 4'h0;
      st_d.tick = 1'b1;
    end
    else
    begin
      st_d.cnt = st_q.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign tick_out = st_q.tick;

endmodule // conv_tick_divider
`default_nettype wire

// ---- rtl/sar_adc_control.sv ----
// Summary of operation
// - Eight-bit successive approximation, stepped at the clock over twelve.
// - A full conversion lasts about 70 us at an 8 MHz oscillator.
// - Writing start while power select is already set begins a conversion and clears the done flag at once.
// - Completion sets the done flag; the result is then valid.
// - One conversion per start write; no automatic repetition.
// - A start during a conversion abandons it and begins anew.
// - The start bit is write-only and always reads as zero.
// - Done raises the interrupt only while the interrupt enable is set.
// - Power select low means power-down; high means powered and ready.
// - Wait mode does not power down; software clears power select itself.
// - Reset aborts conversion and loads the control register with 40h.
// - Control: enable bit 7, done bit 6, start bit 5, power bit 4.
// - Read-only result register at address D0h.
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic       comp_in,
  output logic      [7:0] rdata_out,
  output logic            irq_out,
  output logic      [7:0] dac_code_out,
  output logic            converter_power_out,
  output logic            conversion_active_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Constants and decoding.
  // Step counts fix the conversion length.
  localparam logic [5:0] SAMPLE_LAST = 6'(sar_adc_pkg::SAMPLE_TICKS - 1);
  localparam logic [5:0] BIT_LAST    = 6'(sar_adc_pkg::BIT_TICKS - 1);
  localparam logic [2:0] MSB_IDX     = 3'(sar_adc_pkg::RES_BITS - 1);
  localparam logic [9:0] CONV_CYC    = 10'(sar_adc_pkg::CONV_CYCLES);

  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  sar_adc_pkg::adc_state_s st_q;
  sar_adc_pkg::adc_state_s st_d;

  logic       comp_sync;
  logic       tick;
  logic       ctrl_wr;
  logic       start_go;
  logic       done_now;
  logic [9:0] conv_cyc_q;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator input and step clock.
  level_sync u_comp_sync (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .level_in  (comp_in),
    .level_out (comp_sync)
  );

  conv_tick_divider u_tick (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .restart_in (start_go),
    .run_in     (st_q.phase != sar_adc_pkg::PH_IDLE),
    .tick_out   (tick)
  );

  assign ctrl_wr = wr_in && reg_hit(addr_in, sar_adc_pkg::CTRL_OFS);
  assign start_go = ctrl_wr && wdata_in[sar_adc_pkg::CTRL_START_BIT]
                    && st_q.converter_power_select;
  assign done_now = (st_q.phase == sar_adc_pkg::PH_BITS) && tick
                    && (st_q.tick_cnt == BIT_LAST) && (st_q.bit_idx == 3'h0)
                    && !start_go && !(ctrl_wr
                    && !wdata_in[sar_adc_pkg::CTRL_PWR_BIT]);

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb
  begin
    logic [7:0] decided;
    logic [1:0] ev;
    logic [1:0] clr;
    decided = st_q.trial;
    ev = 2'h0;
    clr = 2'h0;
    st_d = st_q;
    if (ctrl_wr)
    begin
      st_d.done_irq_enable = wdata_in[sar_adc_pkg::CTRL_IE_BIT];
      st_d.converter_power_select = wdata_in[sar_adc_pkg::CTRL_PWR_BIT];
    end
    if (start_go)
    begin
      if (st_q.phase != sar_adc_pkg::PH_IDLE)
      begin
        ev[sar_adc_pkg::EV_ABORT_BIT] = 1'b1;
      end
      st_d.phase = sar_adc_pkg::PH_SAMPLE;
      st_d.tick_cnt = 6'h0;
      st_d.eoc = 1'b0;
      st_d.trial = 8'h00;
    end
    else if ((st_q.phase != sar_adc_pkg::PH_IDLE) && !st_d.converter_power_select)
    begin
      ev[sar_adc_pkg::EV_ABORT_BIT] = 1'b1;
      st_d.phase = sar_adc_pkg::PH_IDLE;
      st_d.trial = 8'h00;
    end
    else if (tick)
    begin
      unique case (st_q.phase)
        sar_adc_pkg::PH_IDLE:
        begin
          st_d.tick_cnt = 6'h0;
        end
        sar_adc_pkg::PH_SAMPLE:
        begin
          if (st_q.tick_cnt == SAMPLE_LAST)
          begin
            st_d.phase = sar_adc_pkg::PH_BITS;
            st_d.tick_cnt = 6'h0;
            st_d.bit_idx = MSB_IDX;
            st_d.trial = 8'h80;
          end
          else
          begin
            st_d.tick_cnt = st_q.tick_cnt + 6'h1;
          end
        end
        sar_adc_pkg::PH_BITS:
        begin
          if (st_q.tick_cnt == BIT_LAST)
          begin
            if (!comp_sync)
            begin
              decided[st_q.bit_idx] = 1'b0;
            end
            st_d.tick_cnt = 6'h0;
            if (st_q.bit_idx == 3'h0)
            begin
              st_d.phase = sar_adc_pkg::PH_IDLE;
              st_d.result = decided;
              st_d.eoc = 1'b1;
              ev[sar_adc_pkg::EV_DONE_BIT] = 1'b1;
              st_d.trial = decided;
            end
            else
            begin
              st_d.bit_idx = st_q.bit_idx - 3'h1;
              decided[st_q.bit_idx - 3'h1] = 1'b1;
              st_d.trial = decided;
            end
          end
          else
          begin
            st_d.tick_cnt = st_q.tick_cnt + 6'h1;
          end
        end
        default:
        begin
          st_d.phase = sar_adc_pkg::PH_IDLE;
        end
      endcase
    end
    if (wr_in && reg_hit(addr_in, sar_adc_pkg::STATUS_OFS))
    begin
      clr = wdata_in[1:0];
    end
    // A new event wins over a clear in the same cycle.
    st_d.status = (st_q.status & ~clr) | ev;
    if (wr_in && reg_hit(addr_in, sar_adc_pkg::MASK_OFS))
    begin
      st_d.mask = wdata_in[1:0];
    end
    st_d.busy = (st_d.phase != sar_adc_pkg::PH_IDLE);
    st_d.irq = (st_d.status[sar_adc_pkg::EV_DONE_BIT]
                && st_d.mask[sar_adc_pkg::EV_DONE_BIT] && st_d.done_irq_enable)
               || (st_d.status[sar_adc_pkg::EV_ABORT_BIT]
                && st_d.mask[sar_adc_pkg::EV_ABORT_BIT]);
    st_d.rdata = 8'h00;
    if (rd_in)
    begin
      if (reg_hit(addr_in, sar_adc_pkg::DATA_OFS))
      begin
        st_d.rdata = st_q.result;
      end
      else if (reg_hit(addr_in, sar_adc_pkg::CTRL_OFS))
      begin
        st_d.rdata[sar_adc_pkg::CTRL_IE_BIT] = st_q.done_irq_enable;
        st_d.rdata[sar_adc_pkg::CTRL_EOC_BIT] = st_q.eoc;
        st_d.rdata[sar_adc_pkg::CTRL_PWR_BIT] = st_q.converter_power_select;
      end
      else if (reg_hit(addr_in, sar_adc_pkg::STATUS_OFS))
      begin
        st_d.rdata[1:0] = st_q.status;
      end
      else if (reg_hit(addr_in, sar_adc_pkg::MASK_OFS))
      begin
        st_d.rdata[1:0] = st_q.mask;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_q <= '0;
      st_q.done_irq_enable <= sar_adc_pkg::CTRL_RESET[sar_adc_pkg::CTRL_IE_BIT];
      st_q.eoc <= sar_adc_pkg::CTRL_RESET[sar_adc_pkg::CTRL_EOC_BIT];
      st_q.converter_power_select <= sar_adc_pkg::CTRL_RESET[sar_adc_pkg::CTRL_PWR_BIT];
      st_q.mask <= sar_adc_pkg::MASK_RESET;
      st_q.phase <= sar_adc_pkg::PH_IDLE;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign rdata_out = st_q.rdata;
  assign irq_out = st_q.irq;
  assign dac_code_out = st_q.trial;
  assign converter_power_out = st_q.converter_power_select;
  assign conversion_active_out = st_q.busy;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      conv_cyc_q <= 10'h000;
    end
    else if (start_go)
    begin
      conv_cyc_q <= 10'h000;
    end
    else if (conv_cyc_q != 10'h3ff)
    begin
      conv_cyc_q <= conv_cyc_q + 10'h001;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence ctrl_read_s;
    rd_in && (addr_in == sar_adc_pkg::CTRL_OFS);
  endsequence

  sequence last_step_s;
    done_now && st_q.done_irq_enable && st_q.mask[sar_adc_pkg::EV_DONE_BIT]
      && !wr_in;
  endsequence

  chk_start_reads_zero: assert property (
    ctrl_read_s |=> (rdata_out[sar_adc_pkg::CTRL_START_BIT] == 1'b0)
      && (rdata_out[sar_adc_pkg::CTRL_EOC_BIT] == $past(st_q.eoc)))
    else $error("start bit or done flag read back wrong");

  chk_start_clears_eoc: assert property (
    start_go |=> !st_q.eoc && (st_q.phase == sar_adc_pkg::PH_SAMPLE)
      && (st_q.tick_cnt == 6'h0) && conversion_active_out)
    else $error("start did not clear done and restart");

  chk_conv_length: assert property (
    done_now |-> (conv_cyc_q == CONV_CYC))
    else $error("conversion length differs from expected cycles");

  chk_done_sets_eoc: assert property (
    done_now |=> st_q.eoc && !conversion_active_out
      && (rdata_out == 8'h00 || $past(rd_in)))
    else $error("completion did not set done flag");

  chk_no_repeat_run: assert property (
    (st_q.phase == sar_adc_pkg::PH_IDLE) && !start_go
      |=> st_q.phase == sar_adc_pkg::PH_IDLE)
    else $error("conversion started without a start write");

  chk_result_hold: assert property (
    !done_now |=> $stable(st_q.result))
    else $error("result changed without completion");

  chk_irq_on_done: assert property (
    last_step_s |=> irq_out ##1 irq_out || $past(wr_in))
    else $error("enabled done interrupt not raised");

  chk_power_down_idle: assert property (
    !converter_power_out |-> !conversion_active_out
      && (st_q.phase == sar_adc_pkg::PH_IDLE))
    else $error("converter running while powered down");

  chk_bit_step: assert property (
    (st_q.phase == sar_adc_pkg::PH_BITS) && tick
      && (st_q.tick_cnt == BIT_LAST) && (st_q.bit_idx != 3'h0)
      && !ctrl_wr
      |=> (st_q.bit_idx == $past(st_q.bit_idx) - 3'h1)
      && (st_q.tick_cnt == 6'h0))
    else $error("successive approximation step wrong");

endmodule // sar_adc_control
`default_nettype wire

// ---- test/analog_input_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module analog_input_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] level_in,
  input  wire logic [7:0] dac_code_in,
  input  wire logic       power_in,
  output logic            comp_out
);
  logic toggle_q;

  initial toggle_q = 1'b0;
  always @(posedge clk_in) toggle_q <= ~toggle_q;

  // One analog line; unpowered gives no settled answer.
  // A half step of offset lets an input equal to the trial keep the bit.
  assign comp_out = power_in ? ({level_in, 1'b1} > {dac_code_in, 1'b0})
                             : toggle_q;
endmodule // analog_input_model
`default_nettype wire

// ---- test/sar_adc_control_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control_bench;
  logic       clk_in   = 1'b0;
  logic       rst_n_in = 1'b0;
  logic [7:0] addr_in  = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in    = 1'b0;
  logic       rd_in    = 1'b0;
  logic [7:0] level    = 8'h00;
  logic       comp;
  logic [7:0] rdata_out;
  logic       irq_out;
  logic [7:0] dac_code;
  logic       power;
  logic       active;
  logic [7:0] rv;
  int         n;
  int         errors     = 0;
  int         n_compared = 0;
  // Edges from the accepting edge to the edge that drops busy.
  localparam int CONV_N = sar_adc_pkg::CONV_CYCLES + 1;

  always #2.5 clk_in = ~clk_in;

  sar_adc_control sar_adc_control_inst (
    .clk_in                (clk_in),
    .rst_n_in              (rst_n_in),
    .addr_in               (addr_in),
    .wdata_in              (wdata_in),
    .wr_in                 (wr_in),
    .rd_in                 (rd_in),
    .comp_in               (comp),
    .rdata_out             (rdata_out),
    .irq_out               (irq_out),
    .dac_code_out          (dac_code),
    .converter_power_out   (power),
    .conversion_active_out (active)
  );

  analog_input_model analog_input_model_inst (
    .clk_in      (clk_in),
    .level_in    (level),
    .dac_code_in (dac_code),
    .power_in    (power),
    .comp_out    (comp)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1;
    d = rdata_out;
  endtask

  // Counts edges from its call until the run ends.
  task automatic wait_idle(output int cnt);
    cnt = 0;
    repeat (2000)
    begin
      @(posedge clk_in);
      #1;
      cnt++;
      if (active === 1'b0)
        return;
    end
    errors++;
    $display("BAD %0t conversion never ended", $time);
    tally_and_finish();
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_in);
    #1;
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_reg(sar_adc_pkg::CTRL_OFS, rv);
    check(rv, sar_adc_pkg::CTRL_RESET);
    rd_reg(sar_adc_pkg::DATA_OFS, rv);
    check(rv, 8'h00);
    rd_reg(sar_adc_pkg::STATUS_OFS, rv);
    check(rv, 8'h00);
    rd_reg(sar_adc_pkg::MASK_OFS, rv);
    check(rv, 8'h01);
    rd_reg(8'he0, rv);
    check(rv, 8'h00);
    check(power, 1'b0);
    check(irq_out, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_convert();
    logic [7:0] lv [4] = '{8'h00, 8'hff, 8'ha5, 8'h5a};
    // Power is selected well before any start.
    wr_reg(sar_adc_pkg::CTRL_OFS, 8'h10);
    settle();
    check(power, 1'b1);
    foreach (lv[i])
    begin
      level <= lv[i];
      wr_reg(sar_adc_pkg::CTRL_OFS, 8'h30);
      rd_reg(sar_adc_pkg::CTRL_OFS, rv);
      check(rv, 8'h10);
      wait_idle(n);
      check(n + 2, CONV_N);
      rd_reg(sar_adc_pkg::DATA_OFS, rv);
      check(rv, lv[i]);
      rd_reg(sar_adc_pkg::CTRL_OFS, rv);
      check(rv, 8'h50);
      check(irq_out, 1'b0);
    end
    repeat (600) @(posedge clk_in);
    #1;
    check(active, 1'b0);
    rd_reg(sar_adc_pkg::DATA_OFS, rv);
    check(rv, 8'h5a);
    $display("test convert done");
  endtask

  task automatic t_restart();
    wr_reg(sar_adc_pkg::STATUS_OFS, 8'h03);
    level <= 8'h33;
    wr_reg(sar_adc_pkg::CTRL_OFS, 8'h30);
    repeat (200) @(posedge clk_in);
    rd_reg(sar_adc_pkg::DATA_OFS, rv);
    check(rv, 8'h5a);
    check(dac_code, 8'h20);
    level <= 8'hc3;
    wr_reg(sar_adc_pkg::CTRL_OFS, 8'h30);
    wait_idle(n);
    check(n, CONV_N);
    rd_reg(sar_adc_pkg::DATA_OFS, rv);
    check(rv, 8'hc3);
    rd_reg(sar_adc_pkg::STATUS_OFS, rv);
    check(rv, 8'h03);
    $display("test restart done");
  endtask

  task automatic t_irq();
    wr_reg(sar_adc_pkg::STATUS_OFS, 8'h03);
    wr_reg(sar_adc_pkg::CTRL_OFS, 8'h90);
    level <= 8'h77;
    wr_reg(sar_adc_pkg::CTRL_OFS, 8'hb0);
    wait_idle(n);
    settle();
    check(irq_out, 1'b1);
    wr_reg(sar_adc_pkg::MASK_OFS, 8'h00);
    settle();
    check(irq_out, 1'b0);
    wr_reg(sar_adc_pkg::MASK_OFS, 8'h01);
    settle();
    check(irq_out, 1'b1);
    wr_reg(sar_adc_pkg::STATUS_OFS, 8'h01);
    settle();
    check(irq_out, 1'b0);
    $display("test irq done");
  endtask

  task automatic t_power();
    wr_reg(sar_adc_pkg::CTRL_OFS, 8'h00);
    settle();
    check(power, 1'b0);
    wr_reg(sar_adc_pkg::CTRL_OFS, 8'h20);
    settle();
    check(active, 1'b0);
    rd_reg(sar_adc_pkg::CTRL_OFS, rv);
    check(rv, 8'h40);
    wr_reg(sar_adc_pkg::CTRL_OFS, 8'h10);
    wr_reg(sar_adc_pkg::CTRL_OFS, 8'h30);
    repeat (50) @(posedge clk_in);
    wr_reg(sar_adc_pkg::CTRL_OFS, 8'h00);
    settle();
    check(active, 1'b0);
    rd_reg(sar_adc_pkg::CTRL_OFS, rv);
    check(rv, 8'h00);
    rd_reg(sar_adc_pkg::STATUS_OFS, rv);
    check(rv, 8'h02);
    check(irq_out, 1'b0);
    wr_reg(sar_adc_pkg::MASK_OFS, 8'h03);
    settle();
    check(irq_out, 1'b1);
    wr_reg(sar_adc_pkg::STATUS_OFS, 8'h02);
    settle();
    check(irq_out, 1'b0);
    $display("test power done");
  endtask

  task automatic t_reset_mid();
    wr_reg(sar_adc_pkg::CTRL_OFS, 8'h90);
    wr_reg(sar_adc_pkg::CTRL_OFS, 8'hb0);
    repeat (100) @(posedge clk_in);
    #1;
    check(active, 1'b1);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    #1;
    check(active, 1'b0);
    check(irq_out, 1'b0);
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd_reg(sar_adc_pkg::CTRL_OFS, rv);
    check(rv, sar_adc_pkg::CTRL_RESET);
    $display("test reset_mid done");
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_convert();
    t_restart();
    t_irq();
    t_power();
    t_reset_mid();
    tally_and_finish();
  end
endmodule // sar_adc_control_bench
`default_nettype wire
